// ==== rtl/ilp_pkg.sv ====
// Purpose: shared constants, types and register map of the indicator lamp logic
// Assumes: 50 MHz system clock, AHB-Lite register access with 32-bit data
// Notes:   one lamp per instance; the other lamps are further instances

package ilp_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SLOT_N    = 5;                   // input slots per lamp
  localparam int SRC_W     = 5;                   // width of a source select
  localparam int SRC_N     = 32;                  // internal signals on offer
  localparam int DATA_W    = 32;                  // bus data width
  localparam int ADDR_W    = 32;                  // bus address width
  localparam int ADDR_LSB  = 2;                   // word aligned decode
  localparam int ADDR_DEC  = 8;                   // decoded address bits

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_DEC-1:0] OFS_CTRL   = 8'h00;  // lamp settings
  localparam logic [ADDR_DEC-1:0] OFS_SELECT = 8'h04;  // source of each slot
  localparam logic [ADDR_DEC-1:0] OFS_STATUS = 8'h08;  // lamp state, read only

  // ----------------------------------------------------------------
  // lamp colour codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ILP_DARK        = 3'h0,
    ILP_GREEN       = 3'h1,
    ILP_RED         = 3'h2,
    ILP_RED_FLASH   = 3'h3,
    ILP_GREEN_FLASH = 3'h4
  } ilp_colour_e;

  // ----------------------------------------------------------------
  // settings carried as one word, msb first
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [SRC_W-1:0]  ack_sel;       // acknowledge source
    ilp_colour_e       act_colour;    // colour while lamp is on
    ilp_colour_e       inact_colour;  // colour while lamp is off
    logic              latch_en;      // hold lamp after pickup
    logic [SLOT_N-1:0] invert;        // per slot inversion
  } ilp_cfg_s;

  typedef logic [SLOT_N-1:0][SRC_W-1:0] ilp_sel_t;  // slot source selects

  typedef struct packed {
    logic combined;   // or of all slots now
    logic latched;    // latch held
    logic lamp_on;    // lamp in active state
    logic red;        // red element lit
    logic green;      // green element lit
  } ilp_stat_s;

  localparam int CFG_W  = $bits(ilp_cfg_s);
  localparam int SEL_W  = $bits(ilp_sel_t);
  localparam int STAT_W = $bits(ilp_stat_s);

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam ilp_cfg_s CFG_RESET = '{ack_sel: 5'h00, act_colour: ILP_RED,
                                     inact_colour: ILP_DARK, latch_en: 1'b0,
                                     invert: 5'h00};
  localparam ilp_sel_t SEL_RESET = '0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ       = 50000;   // system clock in kHz
  localparam int FLASH_HALF_MS = 250;     // half period of the flash in ms
  localparam int FLASH_HALF_CYC = FLASH_HALF_MS * CLK_KHZ;  // 12,500,000 cycles
  localparam int FLASH_CNT_W   = 24;      // holds FLASH_HALF_CYC

  // ----------------------------------------------------------------
  // ahb encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

endpackage

// ==== rtl/ilp_lamp.sv ====
// Purpose: one front panel indicator lamp with slot selection, inversion,
//          or-combination, optional latch with acknowledge and two colours
// Assumes: source signals come from logic on clk_in, so they are not synchronised
// Notes:   settings reached over an AHB-Lite slave with zero wait states
//
// Function
// - each slot passes or inverts its source
// - latch holds lamp on after pickup
// - acknowledge clears only once inputs are gone
// - acknowledge acts only while latching is enabled
// - lamp on shows configured active colour
// - lamp off shows inactive colour, default dark

`timescale 1ns/100ps

module ilp_lamp #(
  parameter int FLASH_HALF = ilp_pkg::FLASH_HALF_CYC  // cycles per flash half period
) (
  // clock and reset
  input  wire logic                              clk_in,
  input  wire logic                              rst_in,
  // internal relay signals offered to the slots
  input  wire logic [ilp_pkg::SRC_N-1:0]         src_in,
  // ahb-lite slave
  input  wire logic                              hsel_in,
  input  wire logic [ilp_pkg::ADDR_W-1:0]        haddr_in,
  input  wire logic [1:0]                        htrans_in,
  input  wire logic                              hwrite_in,
  input  wire logic [2:0]                        hsize_in,
  input  wire logic                              hready_in,
  input  wire logic [ilp_pkg::DATA_W-1:0]        hwdata_in,
  output logic      [ilp_pkg::DATA_W-1:0]        hrdata_out,
  output logic                                   hreadyout_out,
  output logic                                   hresp_out,
  // lamp drive
  output logic                                   lamp_red_out,
  output logic                                   lamp_green_out
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  ilp_pkg::ilp_cfg_s                    cfg_reg;        // lamp settings
  ilp_pkg::ilp_sel_t                    sel_reg;        // slot sources
  logic                                 wr_pend_reg;    // write data phase due
  logic [ilp_pkg::ADDR_DEC-1:0]         wr_addr_reg;    // address of that write
  logic [ilp_pkg::DATA_W-1:0]           hrdata_reg;     // read data phase value
  logic                                 hready_reg;     // always ready once out of reset
  logic [ilp_pkg::FLASH_CNT_W-1:0]      flash_cnt_reg;  // free running divider
  logic                                 flash_ph_reg;   // flash phase, 1 = lit
  logic                                 latched_reg;    // latch holds lamp on
  logic                                 combined_reg;   // registered or of slots
  logic                                 lamp_on_reg;    // registered lamp state
  logic                                 red_reg;        // red element drive
  logic                                 green_reg;      // green element drive
  logic [ilp_pkg::SLOT_N-1:0]           slot_val;       // slot values after inversion
  logic                                 combined;       // or of all slots
  logic                                 ack;            // selected acknowledge level
  logic                                 lamp_on;        // active state now
  ilp_pkg::ilp_colour_e                 colour;         // colour in force now
  logic [1:0]                           drive;          // {red, green} now
  logic                                 addr_ok;        // address phase taken
  logic [ilp_pkg::ADDR_DEC-1:0]         addr_dec;       // decoded address bits
  ilp_pkg::ilp_stat_s                   stat;           // status word
  ilp_pkg::ilp_cfg_s                    cfg_view;       // settings seen by a read
  ilp_pkg::ilp_sel_t                    sel_view;       // selects seen by a read
  logic [ilp_pkg::DATA_W-1:0]           rd_mux;         // read value at address phase

  // ----------------------------------------------------------------
  // colour decode
  // ----------------------------------------------------------------
  // maps a colour and the flash phase to {red, green}; unknown codes stay dark
  function automatic logic [1:0] colour_drive(input ilp_pkg::ilp_colour_e c, input logic ph);
    logic [1:0] d;
    d = 2'h0;
    case (c)
      ilp_pkg::ILP_GREEN:       d = 2'h1;
      ilp_pkg::ILP_RED:         d = 2'h2;
      ilp_pkg::ILP_RED_FLASH:   d = ph ? 2'h2 : 2'h0;
      ilp_pkg::ILP_GREEN_FLASH: d = ph ? 2'h1 : 2'h0;
      default:                  d = 2'h0;              // dark or illegal code
    endcase
    return d;
  endfunction

  // ----------------------------------------------------------------
  // slot and lamp combinational logic
  // ----------------------------------------------------------------
  // each slot picks one source and flips it when its invert bit is set
  always_comb
  begin
    for (int i = 0; i < ilp_pkg::SLOT_N; i++)
    begin
      slot_val[i] = src_in[sel_reg[i]] ^ cfg_reg.invert[i];
    end
  end

  assign combined = |slot_val;
  assign ack      = src_in[cfg_reg.ack_sel];
  assign lamp_on  = combined | latched_reg;
  // active colour while on, inactive colour otherwise
  assign colour   = lamp_on ? cfg_reg.act_colour : cfg_reg.inact_colour;
  assign drive    = colour_drive(colour, flash_ph_reg);

  // ----------------------------------------------------------------
  // latch
  // ----------------------------------------------------------------
  // pickup wins over acknowledge; acknowledge counts only with all slots quiet
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      latched_reg <= 1'b0;
    end
    else if (!cfg_reg.latch_en)
    begin
      latched_reg <= 1'b0;
    end
    else if (combined)
    begin
      latched_reg <= 1'b1;
    end
    else if (ack)
    begin
      latched_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // flash divider
  // ----------------------------------------------------------------
  // free running so every flashing lamp blinks in step
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      flash_cnt_reg <= '0;
      flash_ph_reg  <= 1'b0;
    end
    else if (flash_cnt_reg == ilp_pkg::FLASH_CNT_W'(FLASH_HALF - 1))
    begin
      flash_cnt_reg <= '0;
      flash_ph_reg  <= ~flash_ph_reg;
    end
    else
    begin
      flash_cnt_reg <= flash_cnt_reg + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // lamp outputs and status
  // ----------------------------------------------------------------
  // registered so the pins never glitch while selects change
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      combined_reg <= 1'b0;
      lamp_on_reg  <= 1'b0;
      red_reg      <= 1'b0;
      green_reg    <= 1'b0;
    end
    else
    begin
      combined_reg <= combined;
      lamp_on_reg  <= lamp_on;
      red_reg      <= drive[1];
      green_reg    <= drive[0];
    end
  end

  assign lamp_red_out   = red_reg;
  assign lamp_green_out = green_reg;

  // ----------------------------------------------------------------
  // bus address phase
  // ----------------------------------------------------------------
  assign addr_ok  = hsel_in & hready_in & (htrans_in == ilp_pkg::HTRANS_NONSEQ);
  assign addr_dec = {haddr_in[ilp_pkg::ADDR_DEC-1:ilp_pkg::ADDR_LSB], ilp_pkg::ADDR_LSB'(0)};

  // a write in its data phase lands at the same edge a read samples, so forward it
  always_comb
  begin
    cfg_view = cfg_reg;
    sel_view = sel_reg;
    if (wr_pend_reg && (wr_addr_reg == ilp_pkg::OFS_CTRL))
    begin
      cfg_view = ilp_pkg::ilp_cfg_s'(hwdata_in[ilp_pkg::CFG_W-1:0]);
    end
    if (wr_pend_reg && (wr_addr_reg == ilp_pkg::OFS_SELECT))
    begin
      sel_view = ilp_pkg::ilp_sel_t'(hwdata_in[ilp_pkg::SEL_W-1:0]);
    end
    stat = '{combined: combined_reg, latched: latched_reg, lamp_on: lamp_on_reg,
             red: red_reg, green: green_reg};
    case (addr_dec)
      ilp_pkg::OFS_CTRL:   rd_mux = ilp_pkg::DATA_W'(cfg_view);
      ilp_pkg::OFS_SELECT: rd_mux = ilp_pkg::DATA_W'(sel_view);
      ilp_pkg::OFS_STATUS: rd_mux = ilp_pkg::DATA_W'(stat);
      default:             rd_mux = '0;   // unmapped reads as zero
    endcase
  end

  // ----------------------------------------------------------------
  // bus phases and read data
  // ----------------------------------------------------------------
  // zero wait states: read data is fixed at the address phase edge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      hrdata_reg  <= '0;
      hready_reg  <= 1'b0;
    end
    else
    begin
      hready_reg  <= 1'b1;
      wr_pend_reg <= addr_ok & hwrite_in;
      if (addr_ok)
      begin
        wr_addr_reg <= addr_dec;
      end
      if (addr_ok && !hwrite_in)
      begin
        hrdata_reg <= rd_mux;
      end
    end
  end

  assign hrdata_out    = hrdata_reg;
  assign hreadyout_out = hready_reg;
  assign hresp_out     = ilp_pkg::HRESP_OKAY;

  // ----------------------------------------------------------------
  // settings registers
  // ----------------------------------------------------------------
  // written in the data phase; status and unmapped writes are dropped
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_reg <= ilp_pkg::CFG_RESET;
      sel_reg <= ilp_pkg::SEL_RESET;
    end
    else if (wr_pend_reg)
    begin
      if (wr_addr_reg == ilp_pkg::OFS_CTRL)
      begin
        cfg_reg <= ilp_pkg::ilp_cfg_s'(hwdata_in[ilp_pkg::CFG_W-1:0]);
      end
      if (wr_addr_reg == ilp_pkg::OFS_SELECT)
      begin
        sel_reg <= ilp_pkg::ilp_sel_t'(hwdata_in[ilp_pkg::SEL_W-1:0]);
      end
    end
  end

  // hsize is not checked: only whole word transfers are expected
  logic unused_ok;
  assign unused_ok = ^{hsize_in, haddr_in[ilp_pkg::ADDR_W-1:ilp_pkg::ADDR_DEC], haddr_in[1:0]};

endmodule

// ==== verif/ilp_lamp_sva.sv ====
// Purpose: checker for one indicator lamp
// Assumes: bound into ilp_lamp; settings shadowed from the bus
// Notes:   flash check counts cycles between lit edges, red or green flash
`timescale 1ns/100ps
module ilp_lamp_sva #(
  parameter int FLASH_HALF = 8  // flash half period
) (
  // clock and reset
  input wire logic        clk_in,
  input wire logic        rst_in,
  // relay signals and bus
  input wire logic [31:0] src_in,
  input wire logic        hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0]  htrans_in,
  input wire logic        hwrite_in,
  input wire logic [2:0]  hsize_in,
  input wire logic        hready_in,
  input wire logic [31:0] hwdata_in,
  input wire logic [31:0] hrdata_out,
  input wire logic        hreadyout_out,
  input wire logic        hresp_out,
  // lamp
  input wire logic        lamp_red_out,
  input wire logic        lamp_green_out
);
  ilp_pkg::ilp_cfg_s cfg_q;     // shadow settings
  ilp_pkg::ilp_sel_t sel_q;     // shadow selects
  logic              wr_q;      // write data phase next
  logic [7:0]        adr_q;     // write offset
  logic              comb;      // or of slots
  logic              ack_now;   // acknowledge level
  logic              red_q;     // lamp lit one cycle ago
  logic              chg;       // lit edge seen
  logic              flashing;  // steady red or green flash
  logic [1:0]        nchg;      // edges since flash began
  int                cnt;       // cycles since last edge
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ---------------------------------
  // shadow of the settings
  // ---------------------------------
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cfg_q <= ilp_pkg::CFG_RESET;
      sel_q <= ilp_pkg::SEL_RESET;
      wr_q  <= 1'b0;
      adr_q <= 8'h00;
    end
    else
    begin
      wr_q  <= hsel_in && hready_in && htrans_in == ilp_pkg::HTRANS_NONSEQ && hwrite_in;
      adr_q <= haddr_in[7:0];
      if (wr_q && adr_q == ilp_pkg::OFS_CTRL)
        cfg_q <= ilp_pkg::ilp_cfg_s'(hwdata_in[ilp_pkg::CFG_W-1:0]);
      if (wr_q && adr_q == ilp_pkg::OFS_SELECT)
        sel_q <= hwdata_in[ilp_pkg::SEL_W-1:0];
    end
  end
  // expected or of the slots
  always_comb
  begin
    comb = 1'b0;
    for (int i = 0; i < ilp_pkg::SLOT_N; i++)
      comb = comb | (src_in[sel_q[i]] ^ cfg_q.invert[i]);
  end
  assign ack_now  = src_in[cfg_q.ack_sel];
  assign chg      = (lamp_red_out | lamp_green_out) != red_q;
  assign flashing = comb && (cfg_q.act_colour == ilp_pkg::ILP_RED_FLASH
                             || cfg_q.act_colour == ilp_pkg::ILP_GREEN_FLASH);
  // edge spacing; first two edges skipped since the divider runs free
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      red_q <= 1'b0;
      cnt   <= 0;
      nchg  <= 2'h0;
    end
    else
    begin
      red_q <= lamp_red_out | lamp_green_out;
      cnt   <= chg ? 1 : cnt + 1;
      nchg  <= !flashing ? 2'h0 : (chg && nchg != 2'h3) ? nchg + 2'h1 : nchg;
    end
  end
  okay_resp_a:
    assert property (hresp_out == ilp_pkg::HRESP_OKAY) else $error("response not okay");
  one_colour_a:
    assert property (!(lamp_red_out && lamp_green_out)) else $error("both elements lit");
  pickup_red_a:
    assert property (hreadyout_out && $past(comb) && $past(cfg_q.act_colour) == ilp_pkg::ILP_RED
      |-> lamp_red_out && !lamp_green_out) else $error("lamp not red on pickup");
  pickup_green_a:
    assert property (hreadyout_out && $past(comb) && $past(cfg_q.act_colour) == ilp_pkg::ILP_GREEN
      |-> lamp_green_out && !lamp_red_out) else $error("lamp not green on pickup");
  idle_dark_a:
    assert property (hreadyout_out && $past(comb) == 1'b0 && $past(cfg_q.latch_en) == 1'b0
      && $past(cfg_q.latch_en, 2) == 1'b0 && $past(cfg_q.inact_colour) == ilp_pkg::ILP_DARK
      |-> !lamp_red_out && !lamp_green_out) else $error("idle lamp not dark");
  ack_clear_a:
    assert property (hreadyout_out && cfg_q.latch_en && !comb && ack_now ##1 cfg_q.latch_en && !comb
      && cfg_q.inact_colour == ilp_pkg::ILP_DARK |=> !lamp_red_out && !lamp_green_out)
      else $error("acknowledge did not clear");
  latch_hold_a:
    assert property (hreadyout_out && cfg_q.latch_en && comb ##1 (cfg_q.latch_en && !comb && !ack_now
      && cfg_q.act_colour == ilp_pkg::ILP_RED)[*2] |=> lamp_red_out) else $error("latch lost");
  flash_period_a:
    assert property (flashing && chg && nchg >= 2'h2 |-> cnt == FLASH_HALF) else $error("flash rate");
  cover property (cfg_q.latch_en && !comb && ack_now);
  cover property (flashing && chg && nchg >= 2'h2);
  cover property (comb && cfg_q.invert != 5'h00);
endmodule
bind ilp_lamp ilp_lamp_sva #(.FLASH_HALF(FLASH_HALF)) ilp_lamp_sva_i (
  .clk_in(clk_in), .rst_in(rst_in), .src_in(src_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
  .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(hsize_in), .hready_in(hready_in),
  .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out), .lamp_red_out(lamp_red_out), .lamp_green_out(lamp_green_out));

// ==== verif/tb_top.sv ====
// Purpose: self-checking bench for one indicator lamp
// Assumes: zero wait bus slave, short flash period
// Notes:   reads are scored against a queue of expected words
`timescale 1ns/100ps
module tb_top;
  localparam int FH = 8;         // short flash half period
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic [31:0]       src_in = 32'h0;
  logic              hsel_in = 1'b0;
  logic [31:0]       haddr_in = 32'h0;
  logic [1:0]        htrans_in = 2'h0;
  logic              hwrite_in = 1'b0;
  logic [31:0]       hwdata_in = 32'h0;
  logic [31:0]       hrdata_out;
  logic              hreadyout_out, hresp_out, lamp_red_out, lamp_green_out;
  logic [31:0]       exp_q[$], msk_q[$], ev, mv, v;  // expected reads
  logic              pend = 1'b0;                    // read data phase now
  logic [4:0]        s;
  logic              c;
  int                fails = 0, n_checks = 0, cyc = 0, rnd;
  ilp_pkg::ilp_cfg_s cfg;
  ilp_pkg::ilp_sel_t sel;
  always #10 clk_in = ~clk_in;
  ilp_lamp #(.FLASH_HALF(FH)) ilp_lamp_i (
    .clk_in(clk_in), .rst_in(rst_in), .src_in(src_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hsize_in(3'h2), .hready_in(hreadyout_out),
    .hwdata_in(hwdata_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .lamp_red_out(lamp_red_out), .lamp_green_out(lamp_green_out));
  // ---------------------------------
  // bus master
  // ---------------------------------
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    hsel_in   <= 1'b1;
    haddr_in  <= {24'h0, a};
    htrans_in <= ilp_pkg::HTRANS_NONSEQ;
    hwrite_in <= wr;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    hsel_in   <= 1'b0;
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
  endtask
  // note the expected word, then read
  task automatic chk(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x & m);
    msk_q.push_back(m);
    xfer(1'b0, a, 32'h0);
  endtask
  // change the relay signals and let the lamp settle
  task automatic drive(input logic [31:0] d);
    @(posedge clk_in);
    src_in <= d;
    repeat (3) @(posedge clk_in);
  endtask
  // status word for steady colours
  function automatic logic [31:0] stat(input logic cb, input logic l, input logic [2:0] col);
    return {27'h0, cb, l, cb | l, col == ilp_pkg::ILP_RED, col == ilp_pkg::ILP_GREEN};
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // scoreboard: oldest note against each completed read
  always @(posedge clk_in)
  begin
    if (pend && hreadyout_out === 1'b1)
    begin
      ev = exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF;
      mv = msk_q.size() > 0 ? msk_q.pop_front() : 32'h0;
      n_checks++;
      if ((hrdata_out & mv) !== ev)
      begin
        fails++;
        $display("[FAIL] %0t read %h expected %h", $time, hrdata_out & mv, ev);
      end
    end
    pend <= hsel_in && hreadyout_out && htrans_in == ilp_pkg::HTRANS_NONSEQ && !hwrite_in;
  end
  // hang guard, well above the roughly 470 cycles needed
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      fails++;
      summarize();
    end
  end
  initial
  begin
    rnd = $urandom(32'hDD57);
    repeat (10) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    // reset values, read-only and unmapped places
    chk(ilp_pkg::OFS_CTRL, 32'(ilp_pkg::CFG_RESET), 32'hFFFFFFFF);
    chk(ilp_pkg::OFS_SELECT, 32'h0, 32'hFFFFFFFF);
    xfer(1'b1, ilp_pkg::OFS_STATUS, 32'h1F);
    chk(ilp_pkg::OFS_STATUS, 32'h0, 32'hFFFFFFFF);
    chk(8'h0C, 32'h0, 32'hFFFFFFFF);
    $display("test 1 done");
    // each slot plain then inverted, random source and signals
    for (int i = 0; i < 10; i++)
    begin
      s = 5'($urandom_range(31, 1));
      sel = '0;
      sel[i / 2] = s;
      cfg = ilp_pkg::CFG_RESET;
      cfg.invert[i / 2] = i[0];
      xfer(1'b1, ilp_pkg::OFS_SELECT, 32'(sel));
      xfer(1'b1, ilp_pkg::OFS_CTRL, 32'(cfg));
      v = $urandom() & 32'hFFFFFFFE;
      drive(v);
      c = v[s] ^ i[0];
      chk(ilp_pkg::OFS_STATUS, stat(c, 1'b0, c ? 3'h2 : 3'h0), 32'h1F);
    end
    $display("test 2 done");
    // every colour code as active, a steady one as inactive
    cfg = ilp_pkg::CFG_RESET;  // drop the slot inversion left by the slot test
    xfer(1'b1, ilp_pkg::OFS_SELECT, 32'h0);
    for (int k = 0; k < 5; k++)
    begin
      cfg.act_colour = ilp_pkg::ilp_colour_e'(k);
      cfg.inact_colour = ilp_pkg::ilp_colour_e'((k + 1) % 3);
      xfer(1'b1, ilp_pkg::OFS_CTRL, 32'(cfg));
      drive(32'h1);
      chk(ilp_pkg::OFS_STATUS, stat(1'b1, 1'b0, 3'(k)), k > 2 ? 32'h1C : 32'h1F);
      repeat (4 * FH) @(posedge clk_in);
      drive(32'h0);
      chk(ilp_pkg::OFS_STATUS, stat(1'b0, 1'b0, 3'((k + 1) % 3)), 32'h1F);
    end
    $display("test 3 done");
    // latch, acknowledge refused while input present, then accepted
    cfg = ilp_pkg::CFG_RESET;
    cfg.latch_en = 1'b1;
    cfg.ack_sel = 5'h07;
    xfer(1'b1, ilp_pkg::OFS_CTRL, 32'(cfg));
    drive(32'h1);
    drive(32'h0);
    chk(ilp_pkg::OFS_STATUS, stat(1'b0, 1'b1, 3'h2), 32'h1F);
    drive(32'h81);
    drive(32'h0);
    chk(ilp_pkg::OFS_STATUS, stat(1'b0, 1'b1, 3'h2), 32'h1F);
    drive(32'h80);
    chk(ilp_pkg::OFS_STATUS, stat(1'b0, 1'b0, 3'h0), 32'h1F);
    $display("test 4 done");
    // latching switched off drops the latch; pulses then leave no trace
    drive(32'h1);
    drive(32'h0);
    cfg.latch_en = 1'b0;
    xfer(1'b1, ilp_pkg::OFS_CTRL, 32'(cfg));
    drive(32'h80);
    chk(ilp_pkg::OFS_STATUS, stat(1'b0, 1'b0, 3'h0), 32'h1F);
    drive(32'h1);
    drive(32'h0);
    chk(ilp_pkg::OFS_STATUS, stat(1'b0, 1'b0, 3'h0), 32'h1F);
    $display("test 5 done");
    summarize();
  end
endmodule
